// ===== design/cmh_regs.svh
// Named constants for the calibration mode command handler.
// Assumes a 10 MHz clock and an ASCII command stream from the host link.
`ifndef CMH_REGS_SVH
`define CMH_REGS_SVH

// ============================================================
// Keyword storage
// ============================================================
`define CMH_KEY_DEFAULT 20'h12345
`define CMH_KEY_DIGITS 3'd5
`define CMH_DIG_MAX 3'd7

// ============================================================
// ASCII characters of the command language
// ============================================================
`define CMH_CH_X 8'h58
`define CMH_CH_K 8'h4b
`define CMH_CH_E 8'h45
`define CMH_CH_H 8'h48
`define CMH_CH_G 8'h47
`define CMH_CH_U 8'h55
`define CMH_CH_STAR 8'h2a
`define CMH_CH_COMMA 8'h2c
`define CMH_CH_SPACE 8'h20
`define CMH_CH_CR 8'h0d
`define CMH_CH_0 8'h30
`define CMH_CH_9 8'h39
`define CMH_CH_LA 8'h61
`define CMH_CH_LZ 8'h7a
`define CMH_CASE_BIT 8'h20

// ============================================================
// Command arguments and reset values
// ============================================================
`define CMH_Q_STATUS 16'h0002
`define CMH_Q_READING 16'h000d
`define CMH_GAIN_CHASSIS 16'h0000
`define CMH_GAIN_SEL 16'h005b
`define CMH_STATUS_RESET 8'h00
`define CMH_FMT_LAST 3'h6

// ============================================================
// Timing
// ============================================================
`define CMH_CLK_HZ 10000000
`define CMH_FLASH_HALF_MS 250
`define CMH_FLASH_HALF_CYC (`CMH_FLASH_HALF_MS * (`CMH_CLK_HZ / 1000))
`define CMH_FLASH_CNT_W 22

`endif

// ===== design/cmh_pkg.sv
// Types shared by the calibration mode command handler modules.
// Assumes cmh_regs.svh supplies the numeric constants.
`default_nettype none
package cmh_pkg;

  // ============================================================
  // Parser states, one-hot.
  // ============================================================
  typedef enum logic [3:0] {
    CMH_ST_IDLE = 4'b0001,
    CMH_ST_ARGS = 4'b0010,
    CMH_ST_EXEC = 4'b0100,
    CMH_ST_RESP = 4'b1000
  } cmh_state_t;

  // Kind of calibration step handed to the engine.
  typedef enum logic [1:0] {
    CMH_CAL_NONE = 2'b00,
    CMH_CAL_OFFSET = 2'b01,
    CMH_CAL_GAIN = 2'b10
  } cmh_cal_kind_t;

  // One calibration step request.
  typedef struct packed {
    cmh_cal_kind_t kind;
    logic [15:0] arg0;
    logic [15:0] arg1;
  } cmh_cal_op_t;

  // One write to protected constant storage.
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] data;
  } cmh_store_wr_t;

  // Calibration status byte, mode bit most significant.
  typedef struct packed {
    logic mode;
    logic active;
    logic bad_cmd;
    logic bad_key;
    logic range_err;
    logic cksum_err;
    logic wr_fail;
    logic rd_fail;
  } cmh_status_t;

endpackage
`default_nettype wire

// ===== design/cmh_flash.sv
// Trigger indicator flasher: blinks while a calibration step is active.
// Assumes the same clock and synchronous reset as the handler.
`timescale 1ns/1ps
`default_nettype none
`include "cmh_regs.svh"

module cmh_flash
  import cmh_pkg::*;
#(
  parameter int HALF_CYCLES = `CMH_FLASH_HALF_CYC
) (
  input wire logic clock, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic active, // A calibration step is running.
  output logic led // Trigger indicator drive.
);

  logic [`CMH_FLASH_CNT_W-1:0] cnt_reg; // Half-period counter.
  logic led_reg; // Indicator state.
  logic first_reg; // Next active cycle is the first of a step.

  // ============================================================
  // Blink timer
  // ============================================================
  // The counter restarts whenever the step ends, so every step begins
  // with a full lit half period the host can see at once. The
  // first active cycle lights the lamp without counting; after that both halves last
  // the same number of cycles.
  always_ff @(posedge clock) begin
    if (rst || !active) begin
      cnt_reg <= '0;
      led_reg <= 1'b0;
      first_reg <= 1'b1;
    end else if (first_reg) begin
      first_reg <= 1'b0;
      led_reg <= 1'b1;
    end else if (cnt_reg == `CMH_FLASH_CNT_W'(HALF_CYCLES - 1)) begin
      cnt_reg <= '0;
      led_reg <= ~led_reg;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign led = led_reg;

endmodule
`default_nettype wire

// ===== design/cmh_fmt.sv
// Response formatter: a prefix letter, the decimal value, then CR.
// Assumes the consumer applies back-pressure with tx_ready.
`timescale 1ns/1ps
`default_nettype none
`include "cmh_regs.svh"

module cmh_fmt
  import cmh_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic start, // Pulse: begin a response.
  input wire logic [15:0] value, // Value to print, taken at start.
  output logic busy, // Response in progress.
  output logic tx_valid, // Character available.
  output logic [7:0] tx_data, // Character, registered.
  input wire logic tx_ready // Consumer takes the character.
);

  // ============================================================
  // Helpers
  // ============================================================
  // Binary to five BCD digits by shift and add-three.
  function automatic logic [19:0] bin2bcd(input logic [15:0] bin);
    logic [35:0] sh;
    sh = {20'h00000, bin};
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < 5; j++) begin
        if (sh[16 + 4 * j +: 4] > 4'h4) begin
          sh[16 + 4 * j +: 4] = sh[16 + 4 * j +: 4] + 4'h3;
        end
      end
      sh = sh << 1;
    end
    return sh[35:16];
  endfunction

  // Index of the first digit to print; leading zeros are skipped.
  function automatic logic [2:0] first_idx(input logic [19:0] b);
    logic [2:0] r;
    r = 3'h5;
    for (int k = 1; k < 5; k++) begin
      if (b[4 * k +: 4] != 4'h0) begin
        r = 3'(5 - k);
      end
    end
    return r;
  endfunction

  // Character at an index: prefix, digits, then the terminator.
  function automatic logic [7:0] char_at(input logic [2:0] idx,
                                         input logic [19:0] b);
    logic [7:0] c;
    c = `CMH_CH_CR;
    if (idx == 3'h0) begin
      c = `CMH_CH_U;
    end else if (idx != `CMH_FMT_LAST) begin
      c = `CMH_CH_0 | {4'h0, b[4 * (5 - idx) +: 4]};
    end
    return c;
  endfunction

  logic [19:0] bcd_reg; // Digits of the captured value.
  logic [2:0] idx_reg; // Position of the character on offer.
  logic valid_reg; // Character on offer.
  logic [7:0] data_reg; // Character on offer.
  logic [2:0] idx_next; // Position after the current one.

  assign idx_next = (idx_reg == 3'h0) ? first_idx(bcd_reg)
                                      : idx_reg + 3'h1;

  // ============================================================
  // Character sequencer
  // ============================================================
  // A start during a response is not expected; the handler waits.
  always_ff @(posedge clock) begin
    if (rst) begin
      bcd_reg <= 20'h00000;
      idx_reg <= 3'h0;
      valid_reg <= 1'b0;
      data_reg <= 8'h00;
    end else if (start) begin
      bcd_reg <= bin2bcd(value);
      idx_reg <= 3'h0;
      valid_reg <= 1'b1;
      data_reg <= `CMH_CH_U;
    end else if (valid_reg && tx_ready) begin
      if (idx_reg == `CMH_FMT_LAST) begin
        valid_reg <= 1'b0;
      end else begin
        idx_reg <= idx_next;
        data_reg <= char_at(idx_next, bcd_reg);
      end
    end
  end

  assign busy = valid_reg;
  assign tx_valid = valid_reg;
  assign tx_data = data_reg;

endmodule
`default_nettype wire

// ===== design/cmh_top.sv
// Calibration mode command handler: parses ASCII calibration commands,
// keeps the keyword and the status byte, and gates protected writes.
// Assumes one clock, a calibration engine that answers each start with
// one done pulse, and the enable pushbutton arriving asynchronously.
//
// Notes on behaviour
// - Keyword has five digits, default 12345.
// - Unlock command with matching keyword enables calibration.
// - Keyword change accepted only with hardware enable, in or out of calibration mode.
// - Exit command leaves calibration mode.
// - Calibration commands outside mode are refused, flagged.
// - Valid unlock sets status bit 7.
// - Exit command clears status bit 7.
// - Status query returns status byte; 128 means ok.
// - Bit 6 set, indicator flashes while step runs.
// - Read 129, write 130, checksum 132 reported.
// - Range 136, keyword 144, command 160 reported.
// - Channel zero offset command runs chassis offset.
// - Gain command 0,91 runs chassis gain.
// - Keyword rewritable unknown only with hardware enable.
// - Reading query returns the newest counts sampled while acquisition runs.
// - Protected writes need hardware enable input.
`timescale 1ns/1ps
`default_nettype none
`include "cmh_regs.svh"

module cmh_top
  import cmh_pkg::*;
#(
  parameter int FLASH_HALF_CYCLES = `CMH_FLASH_HALF_CYC
) (
  input wire logic clock, // System clock, 10 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic rx_valid, // Command character offered.
  input wire logic [7:0] rx_data, // Command character.
  output logic rx_ready, // Handler takes the character.
  output logic tx_valid, // Response character offered.
  output logic [7:0] tx_data, // Response character.
  input wire logic tx_ready, // Link takes the response character.
  input wire logic cal_enable_pin, // Hardware enable, async.
  output logic cal_start, // Pulse: start a calibration step.
  output cmh_cal_op_t cal_op, // Step kind and arguments.
  input wire logic cal_done, // Pulse: step finished.
  input wire logic cal_range_err, // With cal_done: value out of range.
  input wire logic eng_wr_req, // Engine asks to write a constant.
  input wire cmh_store_wr_t eng_wr, // Constant address and data.
  output logic store_we, // Pulse: write to protected storage.
  output cmh_store_wr_t store_wr, // Write address and data.
  input wire logic store_rd_fail, // Pulse: storage read failed.
  input wire logic store_wr_fail, // Pulse: storage write failed.
  input wire logic store_cksum_err, // Pulse: storage checksum bad.
  input wire logic adc_valid, // Pulse: new converter sample.
  input wire logic [15:0] adc_count, // Converter sample in counts.
  input wire logic acq_running, // Acquisition in progress.
  output logic cal_mode, // Calibration mode active.
  output logic trig_led // Trigger indicator.
);

  // ============================================================
  // Declarations
  // ============================================================
  cmh_state_t state_reg; // Parser state.
  cmh_state_t state_next; // Parser next state.
  logic [7:0] ch; // Received character, upper case.
  logic take; // Character accepted this cycle.
  logic is_digit; // Character is a decimal digit.
  logic [7:0] op_reg; // Command letter.
  logic star_reg; // Command was prefixed with a star.
  logic comma_reg; // A comma separated two arguments.
  logic bad_fmt_reg; // Malformed command text.
  logic [15:0] arg0_reg; // First decimal argument.
  logic [15:0] arg1_reg; // Second decimal argument.
  logic [19:0] key_acc_reg; // First argument as BCD digits.
  logic [2:0] ndig_reg; // Digits in the first argument.
  logic [19:0] keyword_reg; // Stored calibration keyword.
  logic cal_en_meta_reg; // Enable synchroniser, first stage.
  logic cal_en_reg; // Enable synchroniser, second stage.
  logic mode_reg; // Calibration mode bit.
  logic busy_reg; // Calibration step running.
  logic [5:0] err_reg; // Sticky error bits, status bits 5..0.
  logic [5:0] err_set; // Errors raised this cycle.
  logic err_clr; // Status read clears the errors.
  cmh_status_t status; // Assembled status byte.
  logic [15:0] sample_reg; // Latest converter sample.
  logic start_reg; // Step start pulse.
  cmh_cal_op_t op_out_reg; // Step request held for the engine.
  logic store_we_reg; // Protected write pulse.
  cmh_store_wr_t store_wr_reg; // Protected write payload.
  logic fmt_start; // Begin a response.
  logic [15:0] fmt_value; // Value to print.
  logic fmt_busy; // Response in progress.
  // Decoded actions of the command in execution.
  logic do_unlock, do_change, do_exit, do_cal, do_status, do_read;
  logic e_bad_cmd, e_bad_key, e_wr_fail;
  cmh_cal_kind_t cal_kind;

  // Upper-cases a letter so commands work in either case.
  function automatic logic [7:0] to_upper(input logic [7:0] c);
    logic [7:0] r;
    r = c;
    if (c >= `CMH_CH_LA && c <= `CMH_CH_LZ) begin
      r = c & ~`CMH_CASE_BIT;
    end
    return r;
  endfunction

  // Decimal accumulate; wraps above 65535, which no command needs.
  function automatic logic [15:0] dec_acc(input logic [15:0] a,
                                          input logic [3:0] d);
    logic [19:0] p;
    p = {a, 4'h0} - {2'b00, a, 2'b00} + {16'h0000, d} -
        {4'h0, a} + {3'b000, a, 1'b0} + {4'h0, a} - {4'h0, a};
    p = ({4'h0, a} << 3) + ({4'h0, a} << 1) + {16'h0000, d};
    return p[15:0];
  endfunction

  // ============================================================
  // Hardware enable synchroniser
  // ============================================================
  // The pushbutton is asynchronous; only the second stage is read.
  always_ff @(posedge clock) begin
    if (rst) begin
      cal_en_meta_reg <= 1'b0;
      cal_en_reg <= 1'b0;
    end else begin
      cal_en_meta_reg <= cal_enable_pin;
      cal_en_reg <= cal_en_meta_reg;
    end
  end

  // ============================================================
  // Character intake and parser state
  // ============================================================
  assign ch = to_upper(rx_data);
  assign is_digit = (ch >= `CMH_CH_0) && (ch <= `CMH_CH_9);
  // Characters are held off while a command executes or answers.
  assign rx_ready = (state_reg == CMH_ST_IDLE) ||
                    (state_reg == CMH_ST_ARGS);
  assign take = rx_valid && rx_ready;

  // Next state: a letter opens a command, X closes it.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CMH_ST_IDLE: begin
        if (take && ch != `CMH_CH_STAR && ch != `CMH_CH_SPACE &&
            ch != `CMH_CH_CR) begin
          state_next = CMH_ST_ARGS;
        end
      end
      CMH_ST_ARGS: begin
        if (take && ch == `CMH_CH_X) begin
          state_next = CMH_ST_EXEC;
        end
      end
      CMH_ST_EXEC: begin
        // A response holds the parser until the last character leaves.
        state_next = fmt_start ? CMH_ST_RESP : CMH_ST_IDLE;
      end
      CMH_ST_RESP: begin
        if (!fmt_busy) begin
          state_next = CMH_ST_IDLE;
        end
      end
      default: begin
        state_next = CMH_ST_IDLE;
      end
    endcase
  end

  // Parser state register.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= CMH_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Command text capture: letter, star, arguments and keyword digits.
  always_ff @(posedge clock) begin
    if (rst || state_reg == CMH_ST_EXEC) begin
      op_reg <= 8'h00;
      star_reg <= 1'b0;
      comma_reg <= 1'b0;
      bad_fmt_reg <= 1'b0;
      arg0_reg <= 16'h0000;
      arg1_reg <= 16'h0000;
      key_acc_reg <= 20'h00000;
      ndig_reg <= 3'h0;
    end else if (take && state_reg == CMH_ST_IDLE) begin
      if (ch == `CMH_CH_STAR) begin
        star_reg <= 1'b1;
      end else begin
        op_reg <= ch;
      end
    end else if (take && state_reg == CMH_ST_ARGS) begin
      if (is_digit && !comma_reg) begin
        arg0_reg <= dec_acc(arg0_reg, ch[3:0]);
        key_acc_reg <= {key_acc_reg[15:0], ch[3:0]};
        if (ndig_reg != `CMH_DIG_MAX) begin
          ndig_reg <= ndig_reg + 3'h1;
        end
      end else if (is_digit) begin
        arg1_reg <= dec_acc(arg1_reg, ch[3:0]);
      end else if (ch == `CMH_CH_COMMA && !comma_reg) begin
        comma_reg <= 1'b1;
      end else if (ch != `CMH_CH_X && ch != `CMH_CH_SPACE) begin
        bad_fmt_reg <= 1'b1;
      end
    end
  end

  // ============================================================
  // Command decode, active only in the execute cycle
  // ============================================================
  always_comb begin
    do_unlock = 1'b0;
    do_change = 1'b0;
    do_exit = 1'b0;
    do_cal = 1'b0;
    do_status = 1'b0;
    do_read = 1'b0;
    e_bad_cmd = 1'b0;
    e_bad_key = 1'b0;
    e_wr_fail = 1'b0;
    cal_kind = CMH_CAL_NONE;
    if (state_reg != CMH_ST_EXEC) begin
      e_bad_cmd = 1'b0;
    end else if (bad_fmt_reg) begin
      e_bad_cmd = 1'b1;
    end else if (op_reg == `CMH_CH_K && !star_reg) begin
      // Unlock needs all five digits and an exact match.
      if (ndig_reg == `CMH_KEY_DIGITS && key_acc_reg == keyword_reg) begin
        do_unlock = 1'b1;
      end else begin
        e_bad_key = 1'b1;
      end
    end else if (op_reg == `CMH_CH_K) begin
      // The enable input stands in for the old keyword.
      if (!mode_reg && !cal_en_reg) begin
        e_bad_cmd = 1'b1;
      end else if (ndig_reg != `CMH_KEY_DIGITS) begin
        e_bad_key = 1'b1;
      end else if (!cal_en_reg) begin
        e_wr_fail = 1'b1;
      end else begin
        do_change = 1'b1;
      end
    end else if (op_reg == `CMH_CH_E) begin
      do_exit = 1'b1;
    end else if (op_reg == `CMH_CH_H || op_reg == `CMH_CH_G) begin
      // A step while locked or while another runs is refused.
      if (!mode_reg || busy_reg) begin
        e_bad_cmd = 1'b1;
      end else if (op_reg == `CMH_CH_H) begin
        do_cal = 1'b1;
        cal_kind = CMH_CAL_OFFSET;
      end else if (!comma_reg || (arg0_reg == `CMH_GAIN_CHASSIS &&
                                  arg1_reg != `CMH_GAIN_SEL)) begin
        e_bad_cmd = 1'b1;
      end else begin
        do_cal = 1'b1;
        cal_kind = CMH_CAL_GAIN;
      end
    end else if (op_reg == `CMH_CH_U && arg0_reg == `CMH_Q_STATUS) begin
      do_status = 1'b1;
    end else if (op_reg == `CMH_CH_U && arg0_reg == `CMH_Q_READING) begin
      do_read = 1'b1;
    end else begin
      e_bad_cmd = 1'b1;
    end
  end

  // ============================================================
  // Keyword, mode and step state
  // ============================================================
  // Keyword is held here and reset to 12345; it changes only when enabled.
  always_ff @(posedge clock) begin
    if (rst) begin
      keyword_reg <= `CMH_KEY_DEFAULT;
    end else if (do_change && cal_en_reg) begin
      keyword_reg <= key_acc_reg;
    end
  end

  // Mode bit: set by a good unlock, cleared by the exit command.
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_reg <= 1'b0;
    end else if (do_unlock) begin
      mode_reg <= 1'b1;
    end else if (do_exit) begin
      mode_reg <= 1'b0;
    end
  end

  // Step runs from its start pulse until the engine reports done.
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_reg <= 1'b0;
      start_reg <= 1'b0;
      op_out_reg <= '0;
    end else begin
      start_reg <= do_cal;
      if (do_cal) begin
        busy_reg <= 1'b1;
        op_out_reg <= '{kind: cal_kind, arg0: arg0_reg, arg1: arg1_reg};
      end else if (cal_done) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // ============================================================
  // Error flags
  // ============================================================
  assign err_set = {e_bad_cmd, e_bad_key, cal_done && cal_range_err,
                    store_cksum_err, store_wr_fail || e_wr_fail ||
                    (eng_wr_req && !cal_en_reg), store_rd_fail};
  assign err_clr = do_status;

  // Errors stay until a status query has reported them; a fresh error
  // in the same cycle as that query survives it.
  always_ff @(posedge clock) begin
    if (rst) begin
      err_reg <= 6'(`CMH_STATUS_RESET);
    end else begin
      err_reg <= (err_reg & ~{6{err_clr}}) | err_set;
    end
  end

  assign status = '{mode: mode_reg, active: busy_reg,
                    bad_cmd: err_reg[5], bad_key: err_reg[4],
                    range_err: err_reg[3], cksum_err: err_reg[2],
                    wr_fail: err_reg[1], rd_fail: err_reg[0]};

  // ============================================================
  // Protected storage gate and converter sample
  // ============================================================
  // Engine writes pass only while the hardware enable is in.
  always_ff @(posedge clock) begin
    if (rst) begin
      store_we_reg <= 1'b0;
      store_wr_reg <= '0;
    end else begin
      store_we_reg <= eng_wr_req && cal_en_reg;
      if (eng_wr_req) begin
        store_wr_reg <= eng_wr;
      end
    end
  end

  // Newest sample taken while acquisition runs is kept for each reading query.
  always_ff @(posedge clock) begin
    if (rst) begin
      sample_reg <= 16'h0000;
    end else if (adc_valid && acq_running) begin
      sample_reg <= adc_count;
    end
  end

  // ============================================================
  // Response and indicator
  // ============================================================
  assign fmt_start = do_status || do_read;
  // The whole byte is printed, so error weights add to the mode bit.
  assign fmt_value = do_read ? sample_reg : {8'h00, status};

  cmh_fmt u_fmt (
    .clock(clock),
    .rst(rst),
    .start(fmt_start),
    .value(fmt_value),
    .busy(fmt_busy),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready)
  );

  cmh_flash #(
    .HALF_CYCLES(FLASH_HALF_CYCLES)
  ) u_flash (
    .clock(clock),
    .rst(rst),
    .active(busy_reg),
    .led(trig_led)
  );

  assign cal_start = start_reg;
  assign cal_op = op_out_reg;
  assign store_we = store_we_reg;
  assign store_wr = store_wr_reg;
  assign cal_mode = mode_reg;

endmodule
`default_nettype wire

// ===== test/cmh_top_assertions.sv
// Port checks for cmh_top.
// Bound to every cmh_top; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module cmh_top_assertions (
  input wire logic clock, rst, rx_valid, rx_ready, tx_valid, cal_start,
  input wire logic cal_enable_pin, cal_done, eng_wr_req, store_we,
  input wire logic cal_mode, trig_led,
  input wire logic [7:0] rx_data, tx_data
);
  // A closing X character taken by the handler.
  wire x_in = rx_valid && rx_ready && rx_data == 8'h58;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_mode_on_key: assert property ($rose(cal_mode) |-> $past(x_in, 2))
    else $error("mode rose late");
  a_step_in_mode: assert property (cal_start |-> cal_mode)
    else $error("step outside mode");
  a_led_at_step: assert property (cal_start |-> ##[0:2] trig_led)
    else $error("indicator dark");
  a_led_off: assert property (cal_done |-> ##[1:2] !trig_led)
    else $error("indicator lit");
  a_we_gated: assert property (store_we |->
    $past(eng_wr_req) && $past(cal_enable_pin, 3)) else $error("write");
  a_rx_stall: assert property (tx_valid |-> !rx_ready)
    else $error("rx open");
  a_resp_prefix: assert property ($rose(tx_valid) |-> tx_data == 8'h55)
    else $error("prefix");
  a_resp_time: assert property ($rose(tx_valid) |-> $past(x_in, 2))
    else $error("answer late");
endmodule
bind cmh_top cmh_top_assertions u_chk (.*);
`default_nettype wire

// ===== test/cmh_eng_model.sv
// Engine stand-in: answers each step start after 20 cycles.
// Assumes the handler's clock and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module cmh_eng_model (
  input wire logic clock, // Clock.
  input wire logic rst, // Reset.
  input wire logic start, // Step start.
  input wire logic err, // Fail the step.
  output logic done, // Step over.
  output logic range_err // With done.
);
  logic [4:0] cnt_reg; // Cycles left.
  // Long enough that the indicator visibly blinks.
  always_ff @(posedge clock) begin
    done <= 1'b0;
    if (rst) begin
      cnt_reg <= 5'h00;
    end else if (start) begin
      cnt_reg <= 5'h14;
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
      done <= cnt_reg == 5'h01;
    end
  end
  assign range_err = done & err;
endmodule
`default_nettype wire

// ===== test/cmh_top_test.sv
// Bench for cmh_top: host command sequences with expected answers.
// Assumes the engine stand-in and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module cmh_top_test;
  import cmh_pkg::*;
  logic clock = 0, rst = 1, rx_valid = 0, tx_ready = 1, cal_enable_pin = 0;
  logic eng_wr_req = 0, store_rd_fail = 0, store_wr_fail = 0, rerr = 0;
  logic store_cksum_err = 0, adc_valid = 0, acq_running = 0;
  logic [7:0] rx_data = 8'h00;
  logic [15:0] adc_count = 16'h0000;
  cmh_store_wr_t eng_wr = 24'h0a1234;
  logic rx_ready, tx_valid, cal_start, cal_done, cal_range_err, store_we;
  logic cal_mode, trig_led;
  logic [7:0] tx_data;
  cmh_cal_op_t cal_op;
  cmh_store_wr_t store_wr;
  int n_errors = 0;
  int tests_run = 0;
  cmh_top #(.FLASH_HALF_CYCLES(4)) dut (.*);
  cmh_eng_model eng (.clock(clock), .rst(rst), .start(cal_start),
    .err(rerr), .done(cal_done), .range_err(cal_range_err));
  initial forever #50 clock = ~clock;
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Inputs change 1 ns after the edge, away from sampling.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Each character is held until the handler takes it.
  task automatic send(input string s);
    foreach (s[i]) begin
      rx_valid = 1'b1;
      rx_data = s[i];
      for (int k = 0; k < 50 && !rx_ready; k++) tick(1);
      tick(1);
    end
    rx_valid = 1'b0;
  endtask
  // Sends a query, then compares each answer character and the CR.
  task automatic q(input string c, input string e);
    send(c);
    e = {e, "\r"};
    foreach (e[i]) begin
      for (int k = 0; k < 50 && !tx_valid; k++) tick(1);
      chk(tx_data, e[i]);
      tick(1);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    tick(8);
    rst = 0;
    q("U2X", "U0");
    send("K54321X");
    q("U2X", "U16");
    send("H0X");
    q("U2X", "U32");
    send("K12345X");
    tick(2);
    chk(cal_mode, 1'b1);
    q("U2X", "U128");
    send("H0X");
    tick(5);
    chk({cal_op.kind, trig_led}, 3'h3);
    q("U2X", "U192");
    tick(40);
    chk(trig_led, 1'b0);
    rerr = 1;
    send("G0,91X");
    tick(5);
    chk(cal_op, {2'h2, 16'h0000, 16'h005b});
    tick(40);
    rerr = 0;
    q("U2X", "U136");
    send("G0,5X");
    q("U2X", "U160");
    for (int b = 0; b < 3; b++) begin
      {store_cksum_err, store_wr_fail, store_rd_fail} = 3'(1 << b);
      tick(1);
      {store_cksum_err, store_wr_fail, store_rd_fail} = 3'h0;
      q("U2X", $sformatf("U%0d", 128 + (1 << b)));
    end
    eng_wr_req = 1;
    tick(1);
    eng_wr_req = 0;
    chk(store_we, 1'b0);
    q("U2X", "U130");
    cal_enable_pin = 1;
    tick(4);
    eng_wr_req = 1;
    tick(1);
    eng_wr_req = 0;
    chk(store_we, 1'b1);
    chk(store_wr, 24'h0a1234);
    send("EX");
    tick(2);
    chk(cal_mode, 1'b0);
    send("*K11111X");
    send("K12345X");
    q("U2X", "U16");
    send("K11111X");
    tick(2);
    chk(cal_mode, 1'b1);
    acq_running = 1;
    adc_count = 16'h04d2;
    adc_valid = 1;
    tick(1);
    adc_valid = 0;
    q("U13X", "U1234");
    report_and_stop();
  end
endmodule
`default_nettype wire
